/* design/mux_ctl_pkg.sv */
// Purpose: shared constants and types for the two-wire mux control block
// Assumes: ref_clk at 20 MHz; serial bus at most 400 kHz
// Notes:   offsets, timing counts, single-bit write field positions, MASS_EN_RST and TIMSEL_RST live here
`default_nettype none
package mux_ctl_pkg;
   // ==========================================================
   // timing
   localparam int REF_CLK_NS   = 50;
   localparam int SPIKE_NS     = 50;
   // a spike of SPIKE_NS must never survive, so need one cycle more
   localparam int SPIKE_CYC    = (SPIKE_NS + REF_CLK_NS - 1) / REF_CLK_NS + 1;
   localparam int TIMEOUT1_US  = 30000;
   localparam int TIMEOUT2_US  = 15000;
   localparam int TIMEOUT3_US  = 7500;
   localparam int TIMEOUT1_CYC = TIMEOUT1_US * 1000 / REF_CLK_NS;
   localparam int TIMEOUT2_CYC = TIMEOUT2_US * 1000 / REF_CLK_NS;
   localparam int TIMEOUT3_CYC = TIMEOUT3_US * 1000 / REF_CLK_NS;
   // ==========================================================
   // slave addresses
   localparam logic [6:0] BASE_ADDR  = 7'h40;
   localparam logic [6:0] ARA_ADDR   = 7'h0C;
   localparam logic [6:0] MASS_ADDR  = 7'h5E;
   // ==========================================================
   // register indexes
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_ACCEL  = 8'h01;
   localparam logic [7:0] REG_CONFIG = 8'h02;
   localparam logic [7:0] REG_CONN   = 8'h03;
   // ==========================================================
   // field positions and resets
   localparam int ACC_UP_BIT     = 7;
   localparam int ACC_DOWN_BIT   = 6;
   localparam int CONN_REQ_BIT   = 5;
   localparam int MASS_EN_BIT    = 2;
   localparam int CONN_ONE_BIT   = 7;
   localparam int CONN_TWO_BIT   = 6;
   localparam logic       MASS_EN_RST = 1'h1;
   localparam logic [1:0] TIMSEL_RST  = 2'h0;
   // ==========================================================
   // strap codes from the three-level sense
   localparam logic [1:0] STRAP_LOW   = 2'h0;
   localparam logic [1:0] STRAP_HIGH  = 2'h1;
   localparam logic [1:0] STRAP_FLOAT = 2'h2;
   // ==========================================================
   // byte phase and engine state
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_PTR  = 2'h1;
   localparam logic [1:0] PH_DATA = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_RX     = 3'h1,
      ST_DEC    = 3'h2,
      ST_ACK    = 3'h3,
      ST_TX     = 3'h4,
      ST_TXACK  = 3'h5,
      ST_IGNORE = 3'h6
   } eng_state_t;
endpackage
`default_nettype wire

/* design/glitch_filter.sv */
// Purpose: synchronise a bus pin and reject short spikes
// Assumes: pin idles high; ref_clk far faster than the bus
// Notes:   output moves only after SPIKE_CYC stable samples
`default_nettype none
module glitch_filter (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // pin and filtered level
   input  wire logic rawIn,
   output var  logic filtOut
);
   logic       inMeta;
   logic       syncIn;
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic       next_filtOut;

   // ==========================================================
   // filter
   always_comb begin
      next_cnt     = 2'h0;
      next_filtOut = filtOut;
      if (syncIn != filtOut) begin
         if (cnt + 2'h1 == 2'(mux_ctl_pkg::SPIKE_CYC)) begin
            next_filtOut = syncIn;
         end else begin
            next_cnt = cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inMeta  <= 1'h1;
         syncIn  <= 1'h1;
         cnt     <= 2'h0;
         filtOut <= 1'h1;
      end else begin
         inMeta  <= rawIn;
         syncIn  <= inMeta;
         cnt     <= next_cnt;
         filtOut <= next_filtOut;
      end
   end

   AST_SPIKE_REJECT: assert property (@(posedge ref_clk) disable iff (rst)
      (syncIn != filtOut && cnt == 2'h0) ##1 (syncIn == filtOut) |-> $stable(filtOut))
      else $error("single-sample spike reached filtered output");
endmodule
`default_nettype wire

/* design/two_wire_mux_fault_control.sv */
// Purpose: serial slave, fault alert and connection control of a 1:2 bus mux
// Assumes: downstream levels and fault pins sampled on linkClk
// Notes:   open-drain pins are driven low while their enable is high
`default_nettype none
module two_wire_mux_fault_control #(
   parameter int unsigned TIMEOUT1_CYC = mux_ctl_pkg::TIMEOUT1_CYC,
   parameter int unsigned TIMEOUT2_CYC = mux_ctl_pkg::TIMEOUT2_CYC,
   parameter int unsigned TIMEOUT3_CYC = mux_ctl_pkg::TIMEOUT3_CYC
) (
   // clocks and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       linkClk,
   // upstream bus
   input  wire logic       upstream_clock_line,
   input  wire logic       upstream_data_line,
   output var  logic       upstreamDataOe,
   // configuration pins
   input  wire logic       enable,
   input  wire logic [1:0] addr_strap_0,
   input  wire logic [1:0] addr_strap_1,
   input  wire logic [1:0] addr_strap_2,
   // downstream side
   input  wire logic       channel_one_fault_in,
   input  wire logic       channel_two_fault_in,
   input  wire logic       down_one_data_line,
   input  wire logic       down_one_clock_line,
   input  wire logic       down_two_data_line,
   input  wire logic       down_two_clock_line,
   // switch and status outputs
   output var  logic       connectOne,
   output var  logic       connectTwo,
   output var  logic       upAccelEn,
   output var  logic       downAccelEn,
   output var  logic       alertOe,
   output var  logic       readyOe
);
   // ==========================================================
   // link domain sampling, then a level crossing into ref_clk
   logic [5:0] lnkMeta;
   logic [5:0] lnkSync;
   logic [3:0] lnkState;
   logic [3:0] refMeta;
   logic [3:0] refSync;
   always_ff @(posedge linkClk) begin
      lnkMeta  <= {channel_one_fault_in, channel_two_fault_in, down_one_data_line,
                   down_one_clock_line, down_two_data_line, down_two_clock_line};
      lnkSync  <= lnkMeta;
      lnkState <= {lnkSync[5], lnkSync[4], lnkSync[3] & lnkSync[2], lnkSync[1] & lnkSync[0]};
   end
   logic faultOne, faultTwo, busOneHigh, busTwoHigh;
   assign {faultOne, faultTwo, busOneHigh, busTwoHigh} = refSync;

   // ==========================================================
   // pin synchronisers and filtered upstream lines
   logic       enMeta, enSync;
   logic [5:0] strapMeta, strapSync;
   logic       sclF, sdaF, sclPrev, sdaPrev;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refMeta   <= 4'hF;
         refSync   <= 4'hF;
         enMeta    <= 1'h0;
         enSync    <= 1'h0;
         strapMeta <= 6'h00;
         strapSync <= 6'h00;
         sclPrev   <= 1'h1;
         sdaPrev   <= 1'h1;
      end else begin
         refMeta   <= lnkState;
         refSync   <= refMeta;
         enMeta    <= enable;
         enSync    <= enMeta;
         strapMeta <= {addr_strap_2, addr_strap_1, addr_strap_0};
         strapSync <= strapMeta;
         sclPrev   <= sclF;
         sdaPrev   <= sdaF;
      end
   end
   // 20 MHz sampling gives about 25 samples per phase at 400 kHz
   glitch_filter u_scl_filter (.ref_clk(ref_clk), .rst(rst),
      .rawIn(upstream_clock_line), .filtOut(sclF));
   glitch_filter u_sda_filter (.ref_clk(ref_clk), .rst(rst),
      .rawIn(upstream_data_line), .filtOut(sdaF));

   logic sclRise, sclFall, startCond, stopCond;
   assign sclRise   = sclF & ~sclPrev;
   assign sclFall   = ~sclF & sclPrev;
   assign startCond = sclF & sclPrev & sdaPrev & ~sdaF;
   assign stopCond  = sclF & sclPrev & ~sdaPrev & sdaF;

   // ==========================================================
   // address from straps
   function automatic logic [6:0] strapWeight(input logic [1:0] code);
      unique case (code)
         mux_ctl_pkg::STRAP_FLOAT: strapWeight = 7'h01;
         mux_ctl_pkg::STRAP_HIGH:  strapWeight = 7'h02;
         default:                  strapWeight = 7'h00;
      endcase
   endfunction
   logic [6:0] ownAddr;
   assign ownAddr = mux_ctl_pkg::BASE_ADDR + strapWeight(strapSync[1:0])
      + 7'(3 * strapWeight(strapSync[3:2])) + 7'(9 * strapWeight(strapSync[5:4]));

   // ==========================================================
   // register state declarations and read mux
   logic        connOne, connTwo, connReq, massEn, accUp, accDown, failed, latchedTo;
   logic [1:0]  timSel;
   logic [19:0] stuckCnt, stuckLimit;
   logic        stuckOn, realTime;

   function automatic logic [7:0] readReg(input logic [7:0] idx);
      unique case (idx)
         mux_ctl_pkg::REG_STATUS: readReg = {connOne | connTwo, faultOne, faultTwo, 2'h0,
                                             ~failed, latchedTo, realTime};
         mux_ctl_pkg::REG_ACCEL:  readReg = {accUp, accDown, 6'h00};
         mux_ctl_pkg::REG_CONFIG: readReg = {2'h0, connReq, 2'h0, massEn, timSel};
         mux_ctl_pkg::REG_CONN:   readReg = {connOne, connTwo, 4'h0, busOneHigh, busTwoHigh};
         default:                 readReg = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // serial engine
   mux_ctl_pkg::eng_state_t state, next_state;
   logic [2:0] bitCnt, next_bitCnt;
   logic [7:0] shift, next_shift, ptr, next_ptr;
   logic [1:0] phase, next_phase;
   logic       isRead, next_isRead, araMode, next_araMode, next_sdaOe;
   logic       wrStrobe;

   always_comb begin
      next_state   = state;
      next_bitCnt  = bitCnt;
      next_shift   = shift;
      next_ptr     = ptr;
      next_phase   = phase;
      next_isRead  = isRead;
      next_araMode = araMode;
      next_sdaOe   = upstreamDataOe;
      wrStrobe     = 1'h0;
      if (!enSync) begin
         next_state = mux_ctl_pkg::ST_IDLE;
         next_sdaOe = 1'h0;
      end else if (startCond) begin
         next_state  = mux_ctl_pkg::ST_RX;
         next_bitCnt = 3'h0;
         next_phase  = mux_ctl_pkg::PH_ADDR;
         next_sdaOe  = 1'h0;
      end else if (stopCond) begin
         next_state = mux_ctl_pkg::ST_IDLE;
         next_sdaOe = 1'h0;
      end else begin
         unique case (state)
            mux_ctl_pkg::ST_IDLE, mux_ctl_pkg::ST_IGNORE: begin
            end
            mux_ctl_pkg::ST_RX: if (sclRise) begin
               next_shift  = {shift[6:0], sdaF};
               next_bitCnt = bitCnt + 3'h1;
               if (bitCnt == 3'h7) next_state = mux_ctl_pkg::ST_DEC;
            end
            mux_ctl_pkg::ST_DEC: if (sclFall) begin
               next_state = mux_ctl_pkg::ST_ACK;
               next_sdaOe = 1'h1;
               if (phase == mux_ctl_pkg::PH_ADDR) begin
                  next_isRead  = shift[0];
                  next_araMode = 1'h0;
                  if (shift[7:1] == ownAddr) begin
                     next_phase = mux_ctl_pkg::PH_PTR;
                     if (shift[0]) next_shift = readReg(ptr);
                  end else if (shift[7:1] == mux_ctl_pkg::ARA_ADDR && shift[0] && alertOe) begin
                     next_araMode = 1'h1;
                     next_shift   = {ownAddr, 1'h0};
                  end else if (shift[7:1] == mux_ctl_pkg::MASS_ADDR && !shift[0] && massEn) begin
                     next_phase = mux_ctl_pkg::PH_PTR;
                  end else begin
                     next_state = mux_ctl_pkg::ST_IGNORE;
                     next_sdaOe = 1'h0;
                  end
               end else if (phase == mux_ctl_pkg::PH_PTR) begin
                  next_ptr   = shift;
                  next_phase = mux_ctl_pkg::PH_DATA;
               end else begin
                  wrStrobe = 1'h1;
                  next_ptr = ptr + 8'h01;
               end
            end
            mux_ctl_pkg::ST_ACK: if (sclFall) begin
               next_bitCnt = 3'h0;
               next_state  = isRead ? mux_ctl_pkg::ST_TX : mux_ctl_pkg::ST_RX;
               next_sdaOe  = isRead & ~shift[7];
            end
            mux_ctl_pkg::ST_TX: begin
               if (sclRise) begin
                  // another responder pulling low wins the arbitration
                  if (shift[7] && !sdaF) begin
                     next_state = mux_ctl_pkg::ST_IGNORE;
                     next_sdaOe = 1'h0;
                  end else begin
                     next_shift  = {shift[6:0], 1'h0};
                     next_bitCnt = bitCnt + 3'h1;
                     if (bitCnt == 3'h7) next_state = mux_ctl_pkg::ST_TXACK;
                  end
               end else if (sclFall) begin
                  next_sdaOe = ~shift[7];
               end
            end
            mux_ctl_pkg::ST_TXACK: begin
               if (sclFall) begin
                  next_sdaOe = 1'h0;
               end else if (sclRise) begin
                  if (sdaF || araMode) begin
                     next_state = mux_ctl_pkg::ST_IGNORE;
                  end else begin
                     next_ptr    = ptr + 8'h01;
                     next_shift  = readReg(ptr + 8'h01);
                     next_bitCnt = 3'h0;
                     next_state  = mux_ctl_pkg::ST_TX;
                  end
               end
            end
            default: begin
               next_state = mux_ctl_pkg::ST_IDLE;
               next_sdaOe = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state          <= mux_ctl_pkg::ST_IDLE;
         bitCnt         <= 3'h0;
         shift          <= 8'h00;
         ptr            <= 8'h00;
         phase          <= mux_ctl_pkg::PH_ADDR;
         isRead         <= 1'h0;
         araMode        <= 1'h0;
         upstreamDataOe <= 1'h0;
      end else begin
         state          <= next_state;
         bitCnt         <= next_bitCnt;
         shift          <= next_shift;
         ptr            <= next_ptr;
         phase          <= next_phase;
         isRead         <= next_isRead;
         araMode        <= next_araMode;
         upstreamDataOe <= next_sdaOe;
      end
   end

   // ==========================================================
   // control registers, stuck-low timer, alert and ready
   logic        next_connOne, next_connTwo, next_connReq, next_massEn, next_accUp;
   logic        next_accDown, next_failed, next_latchedTo, next_alertOe, next_readyOe;
   logic [1:0]  next_timSel;
   logic [19:0] next_stuckCnt;

   always_comb begin
      unique case (timSel)
         2'h1:    stuckLimit = 20'(TIMEOUT1_CYC);
         2'h2:    stuckLimit = 20'(TIMEOUT2_CYC);
         2'h3:    stuckLimit = 20'(TIMEOUT3_CYC);
         2'h0:    stuckLimit = 20'h0_0000;
      endcase
   end
   assign stuckOn  = (timSel != 2'h0) & (connOne | connTwo) & (~sclF | ~sdaF);
   assign realTime = stuckOn & (stuckCnt == stuckLimit);

   always_comb begin
      next_connOne   = connOne;
      next_connTwo   = connTwo;
      next_connReq   = connReq;
      next_massEn    = massEn;
      next_accUp     = accUp;
      next_accDown   = accDown;
      next_timSel    = timSel;
      next_failed    = failed;
      next_latchedTo = latchedTo;
      next_stuckCnt  = !stuckOn ? 20'h0_0000 : (realTime ? stuckCnt : stuckCnt + 20'h0_0001);
      if (wrStrobe) begin
         unique case (ptr)
            mux_ctl_pkg::REG_STATUS: begin
               next_failed    = 1'h0;
               next_latchedTo = 1'h0;
            end
            mux_ctl_pkg::REG_ACCEL: begin
               next_accUp   = shift[mux_ctl_pkg::ACC_UP_BIT];
               next_accDown = shift[mux_ctl_pkg::ACC_DOWN_BIT];
            end
            mux_ctl_pkg::REG_CONFIG: begin
               next_connReq = shift[mux_ctl_pkg::CONN_REQ_BIT];
               next_massEn  = shift[mux_ctl_pkg::MASS_EN_BIT];
               next_timSel  = shift[1:0];
            end
            mux_ctl_pkg::REG_CONN: begin
               // level check uses the current requirement setting
               next_connOne = shift[mux_ctl_pkg::CONN_ONE_BIT] & (connReq | busOneHigh);
               next_connTwo = shift[mux_ctl_pkg::CONN_TWO_BIT] & (connReq | busTwoHigh);
               if ((shift[mux_ctl_pkg::CONN_ONE_BIT] & ~connReq & ~busOneHigh) |
                   (shift[mux_ctl_pkg::CONN_TWO_BIT] & ~connReq & ~busTwoHigh)) begin
                  next_failed = 1'h1;
               end
            end
            default: begin
            end
         endcase
      end
      // a timeout in the clearing cycle still latches
      if (realTime) begin
         next_latchedTo = 1'h1;
         next_connOne   = 1'h0;
         next_connTwo   = 1'h0;
      end
      if (!enSync) begin
         next_connOne   = 1'h0;
         next_connTwo   = 1'h0;
         next_connReq   = 1'h0;
         next_massEn    = mux_ctl_pkg::MASS_EN_RST;
         next_accUp     = 1'h0;
         next_accDown   = 1'h0;
         next_timSel    = mux_ctl_pkg::TIMSEL_RST;
         next_failed    = 1'h0;
         next_latchedTo = 1'h0;
         next_stuckCnt  = 20'h0_0000;
      end
      next_alertOe = ~faultOne | ~faultTwo | next_latchedTo | next_failed;
      next_readyOe = ~(next_connOne | next_connTwo);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         connOne   <= 1'h0;
         connTwo   <= 1'h0;
         connReq   <= 1'h0;
         massEn    <= mux_ctl_pkg::MASS_EN_RST;
         accUp     <= 1'h0;
         accDown   <= 1'h0;
         timSel    <= mux_ctl_pkg::TIMSEL_RST;
         failed    <= 1'h0;
         latchedTo <= 1'h0;
         stuckCnt  <= 20'h0_0000;
         alertOe   <= 1'h0;
         readyOe   <= 1'h1;
      end else begin
         connOne   <= next_connOne;
         connTwo   <= next_connTwo;
         connReq   <= next_connReq;
         massEn    <= next_massEn;
         accUp     <= next_accUp;
         accDown   <= next_accDown;
         timSel    <= next_timSel;
         failed    <= next_failed;
         latchedTo <= next_latchedTo;
         stuckCnt  <= next_stuckCnt;
         alertOe   <= next_alertOe;
         readyOe   <= next_readyOe;
      end
   end
   assign connectOne  = connOne;
   assign connectTwo  = connTwo;
   assign upAccelEn   = accUp;
   assign downAccelEn = accDown;

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic decFall;
   assign decFall = state == mux_ctl_pkg::ST_DEC && sclFall && enSync && !startCond && !stopCond
                    && phase == mux_ctl_pkg::PH_ADDR;
   sequence seqAraHit;
      decFall && shift == {mux_ctl_pkg::ARA_ADDR, 1'h1} && alertOe && shift[7:1] != ownAddr;
   endsequence
   sequence seqWake;
      $rose(enSync) ##[1:1000] (enSync && startCond);
   endsequence

   AST_FAULT_ALERT: assert property (!(faultOne && faultTwo) |=> alertOe)
      else $error("channel fault did not pull alert");
   AST_STUCK_ALERT: assert property (realTime && enSync |=> latchedTo && alertOe && !connOne)
      else $error("stuck bus did not latch alert");
   AST_REFUSE: assert property (wrStrobe && ptr == mux_ctl_pkg::REG_CONN && shift[7]
      && !connReq && !busOneHigh |=> !connOne && failed && alertOe)
      else $error("connection to low channel not refused");
   AST_DISABLED: assert property (!enSync |=> state == mux_ctl_pkg::ST_IDLE
      && !connOne && !connTwo && !connReq && massEn && !latchedTo && !upstreamDataOe)
      else $error("disabled device kept state");
   AST_REENABLE: assert property (seqWake |=> state == mux_ctl_pkg::ST_RX)
      else $error("start ignored after enable returned");
   AST_READY: assert property (##1 readyOe == !(connOne || connTwo))
      else $error("ready does not match connection");
   AST_OWN_ACK: assert property (decFall && shift[7:1] == ownAddr
      |=> upstreamDataOe && state == mux_ctl_pkg::ST_ACK)
      else $error("own address not acknowledged");
   AST_ARA: assert property (seqAraHit |=> araMode && upstreamDataOe ##1 shift[7:1] == ownAddr)
      else $error("alert response not taken");
   AST_CLEAR: assert property (wrStrobe && ptr == mux_ctl_pkg::REG_STATUS && !realTime
      |=> !latchedTo && !failed && $stable(connOne) && $stable(connReq))
      else $error("status write did not clear latched faults");
   AST_FORCE: assert property (wrStrobe && ptr == mux_ctl_pkg::REG_CONN && shift[7]
      && connReq && !realTime |=> connOne)
      else $error("forced connection not made");
   AST_HOLD: assert property (latchedTo && !wrStrobe && enSync |=> latchedTo && alertOe)
      else $error("latched fault dropped without clear");
endmodule
`default_nettype wire

/* verif/i2c_host_model.sv */
// Purpose: upstream host that bit-bangs write and alert-response frames
// Assumes: bus pulled up; quarter bit is 13 ref_clk
// Notes:   clock stands high between frames
`default_nettype none
module i2c_host_model (
   // clock
   input  wire logic ref_clk,
   // bus
   input  wire logic devOe,
   input  wire logic spikeOn,
   output var  logic sclLine,
   output wire logic sdaLine
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sdaDrv = 1'b1;
   initial sclLine = 1'b1;
   // pull-up: released line reads high
   assign sdaLine = sdaDrv & ~devOe;
   task automatic e(input logic s, input logic c);
      sdaDrv = s;
      sclLine = c;
      // 2.6 us bit, under the 400 kHz ceiling
      repeat (6) @(posedge ref_clk);
      #2;
      // 50 ns clock spike mid low phase, one sample wide
      if (spikeOn && !c) sclLine = 1'b1;
      @(posedge ref_clk);
      #2;
      sclLine = c;
      repeat (6) @(posedge ref_clk);
      #2;
   endtask
   task automatic bitx(input logic v, output logic smp);
      e(v, 1'b0);
      e(v, 1'b1);
      smp = sdaLine;
      e(v, 1'b1);
      e(v, 1'b0);
   endtask
   task automatic stp;
      e(1'b0, 1'b0);
      e(1'b0, 1'b1);
      e(1'b1, 1'b1);
   endtask
   task automatic wr(input logic [23:0] f, output logic ack);
      logic v;
      logic s;
      ack = 1'b1;
      e(1'b0, 1'b1);
      e(1'b0, 1'b0);
      for (int j = 0; j < 27; j++) begin
         v = (j % 9 == 8) ? 1'b1 : f[23 - 8 * (j / 9) - j % 9];
         bitx(v, s);
         if (j % 9 == 8) ack &= ~s;
      end
      stp;
   endtask
   // alert response read: address, ack, one byte in, master nack
   task automatic ara(output logic [7:0] rx, output logic ack);
      logic [7:0] f;
      logic       s;
      f = {mux_ctl_pkg::ARA_ADDR, 1'b1};
      rx = 8'h00;
      ack = 1'b0;
      e(1'b0, 1'b1);
      e(1'b0, 1'b0);
      for (int j = 0; j < 18; j++) begin
         bitx((j < 8) ? f[7 - j] : 1'b1, s);
         if (j == 8) ack = ~s;
         if (j > 8 && j < 17) rx = {rx[6:0], s};
      end
      stp;
   endtask
endmodule
`default_nettype wire

/* verif/tb_two_wire_mux_fault_control.sv */
// Purpose: self-checking bench of the mux fault and connect control
// Assumes: straps high, float, low give address 0x45
// Notes:   stuck-low limits shortened to 200/100/50 cycles
`default_nettype none
module tb_two_wire_mux_fault_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic enable = 1'b1;
   logic fOne = 1'b1;
   logic fTwo = 1'b1;
   logic dOne = 1'b1;
   logic dTwo = 1'b1;
   logic spk = 1'b0;
   logic [1:0] strapTop = mux_ctl_pkg::STRAP_LOW;
   logic [7:0] devAddr = 8'h8A;
   logic [7:0] rx;
   logic scl, sda, dataOe, cOne, cTwo, aUp, aDn, alertOe, readyOe, ack;
   wire logic [7:0] outs = {2'h0, cOne, cTwo, aUp, aDn, alertOe, readyOe};
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   initial forever #25 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #16 linkClk = ~linkClk;
   end
   two_wire_mux_fault_control #(.TIMEOUT1_CYC(200), .TIMEOUT2_CYC(100), .TIMEOUT3_CYC(50))
   dut_u (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .upstream_clock_line(scl),
      .upstream_data_line(sda), .upstreamDataOe(dataOe), .enable(enable),
      .addr_strap_0(mux_ctl_pkg::STRAP_HIGH), .addr_strap_1(mux_ctl_pkg::STRAP_FLOAT),
      .addr_strap_2(strapTop), .channel_one_fault_in(fOne),
      .channel_two_fault_in(fTwo), .down_one_data_line(dOne), .down_one_clock_line(dOne),
      .down_two_data_line(dTwo), .down_two_clock_line(dTwo), .connectOne(cOne),
      .connectTwo(cTwo), .upAccelEn(aUp), .downAccelEn(aDn), .alertOe(alertOe),
      .readyOe(readyOe));
   i2c_host_model host_u (.ref_clk(ref_clk), .devOe(dataOe), .spikeOn(spk), .sclLine(scl),
      .sdaLine(sda));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      host_u.wr({devAddr, p, d}, ack);
      cyc(4);
   endtask
   task automatic t_fault;
      fOne = 1'b0;
      cyc(20);
      chk(outs, 8'h03);
      fOne = 1'b1;
      cyc(20);
      chk(outs, 8'h01);
      fTwo = 1'b0;
      cyc(20);
      chk(outs, 8'h03);
      fTwo = 1'b1;
      cyc(20);
   endtask
   task automatic t_connect;
      spk = 1'b1;
      wr(mux_ctl_pkg::REG_ACCEL, 8'hC0);
      spk = 1'b0;
      chk({7'h0, ack}, 8'h01);
      chk(outs, 8'h0D);
      wr(mux_ctl_pkg::REG_CONFIG, 8'h24);
      dOne = 1'b0;
      wr(mux_ctl_pkg::REG_CONN, 8'h80);
      chk(outs, 8'h2C);
   endtask
   task automatic t_enable;
      enable = 1'b0;
      cyc(10);
      chk(outs, 8'h01);
      wr(mux_ctl_pkg::REG_CONN, 8'h80);
      chk({7'h0, ack}, 8'h00);
      enable = 1'b1;
      cyc(10);
      wr(mux_ctl_pkg::REG_CONN, 8'h80);
      chk({7'h0, ack}, 8'h01);
      chk(outs, 8'h03);
      dOne = 1'b1;
      wr(mux_ctl_pkg::REG_STATUS, 8'h00);
      chk(outs, 8'h01);
   endtask
   task automatic t_stuck;
      wr(mux_ctl_pkg::REG_CONFIG, 8'h01);
      wr(mux_ctl_pkg::REG_CONN, 8'h80);
      chk(outs, 8'h20);
      // clock held low past the 200-cycle limit
      repeat (17) host_u.e(1'b1, 1'b0);
      host_u.e(1'b1, 1'b1);
      chk(outs, 8'h03);
      cyc(20);
      chk(outs, 8'h03);
      wr(mux_ctl_pkg::REG_STATUS, 8'h00);
      chk(outs, 8'h01);
   endtask
   task automatic t_ara;
      host_u.ara(rx, ack);
      chk({7'h0, ack}, 8'h00);
      fTwo = 1'b0;
      cyc(20);
      host_u.ara(rx, ack);
      chk({7'h0, ack}, 8'h01);
      chk(rx, 8'h8A);
      fTwo = 1'b1;
      cyc(20);
   endtask
   task automatic t_strap;
      // top strap high: 0x40 + 2 + 3 + 18 gives 0x57
      strapTop = mux_ctl_pkg::STRAP_HIGH;
      cyc(4);
      wr(mux_ctl_pkg::REG_ACCEL, 8'h80);
      chk({7'h0, ack}, 8'h00);
      devAddr = 8'hAE;
      wr(mux_ctl_pkg::REG_ACCEL, 8'h80);
      chk({7'h0, ack}, 8'h01);
      chk(outs, 8'h09);
   endtask
   task automatic end_of_test;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) num_errors++;
      if (cycles == 40000) end_of_test;
   end
   initial begin
      cyc(12);
      rst = 1'b0;
      cyc(10);
      chk(outs, 8'h01);
      t_fault;
      t_connect;
      t_enable;
      t_stuck;
      t_ara;
      t_strap;
      end_of_test;
   end
endmodule
`default_nettype wire
